/* qucsr_top.sv */
// top of the host port: channel select, resets, strap modes and shared registers
`timescale 1ns/1ns
`default_nettype none
module qucsr_top
  import qucsr_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic ARST_N,
  // host bus
  input wire logic CS_N,
  input wire logic READ_STROBE_N,
  input wire logic WRITE_STROBE_N,
  input wire logic [ADR_W-1:0] ADDR,
  input wire logic [DAT_W-1:0] DATA_IN,
  output logic [DAT_W-1:0] DATA_OUT,
  output logic DATA_OE,
  // straps
  input wire logic BUS_STYLE,
  input wire logic INFRARED_STRAP,
  // timer clock
  input wire logic TIMER_EXT_CLOCK,
  // serial channels, bit n is channel n
  input wire logic [CH_NUM-1:0] CH_SERIAL_IN,
  output logic [CH_NUM-1:0] CH_SERIAL_OUT,
  // modem lines, bit n is channel n
  output logic [CH_NUM-1:0] CH_REQUEST_SEND_N,
  output logic [CH_NUM-1:0] CH_TERMINAL_READY_N,
  input wire logic [CH_NUM-1:0] CH_CLEAR_SEND_N,
  input wire logic [CH_NUM-1:0] CH_SET_READY_N,
  input wire logic [CH_NUM-1:0] CH_CARRIER_DETECT_N,
  input wire logic [CH_NUM-1:0] CH_RING_INDICATOR_N
);
  typedef struct packed {
    logic boot;
    logic [CH_NUM-1:0] chan_init;
    logic [7:0] bcast;
    logic [7:0] tmr_ctl;
    logic [CNT_W-1:0] tmr_cnt;
    logic ext_s1;
    logic ext_s2;
    logic ext_s3;
    logic [DAT_W-1:0] dout;
    logic doe;
  } qucsr_top_t;

  // boot set so the strap is caught on the second edge after release
  localparam qucsr_top_t ST_RST = '{1'b1, CH_NONE, REG_RST, REG_RST, CNT_RST,
                                    1'b0, 1'b0, 1'b0, REG_RST, 1'b0};

  qucsr_top_t st;
  qucsr_top_t next_st;
  logic rst_meta;
  logic rst_sync;
  logic wr_pulse;
  logic rd_act;
  logic cfg_sel;
  logic chan_ok;
  logic [1:0] chan;
  logic [IDX_W-1:0] reg_idx;
  logic [DAT_W-1:0] wdata;
  logic [CH_NUM-1:0] chan_wr;
  logic [DAT_W-1:0] chan_rd [CH_NUM];
  logic cfg_wr;
  logic ext_edge;
  logic tmr_tick;

  // reset release through two flops; assertion is still immediate
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // strobe and address decode
  qucsr_bus_decode u_decode (
    .clk(CLK),
    .rst_n(rst_sync),
    .cs_n(CS_N),
    .rd_n(READ_STROBE_N),
    .wr_n(WRITE_STROBE_N),
    .addr(ADDR),
    .wdata(DATA_IN),
    .bus_style(BUS_STYLE),
    .wr_pulse(wr_pulse),
    .rd_act(rd_act),
    .cfg_sel(cfg_sel),
    .chan_ok(chan_ok),
    .chan(chan),
    .reg_idx(reg_idx),
    .data(wdata)
  );

  // writes with bit 7 set never reach a channel
  assign cfg_wr = wr_pulse && cfg_sel;

  // the four channels; broadcast overrides the channel field on writes
  generate
    for (genvar i = 0; i < CH_NUM; i++)
    begin : g_ch
      assign chan_wr[i] = wr_pulse && chan_ok &&
                          (st.bcast[BCAST_EN] || chan == 2'(i));
      qucsr_channel u_ch (
        .clk(CLK),
        .rst_n(rst_sync),
        .init(st.chan_init[i]),
        .strap(INFRARED_STRAP),
        .wr_en(chan_wr[i]),
        .reg_idx(reg_idx),
        .wdata(wdata),
        .rdata(chan_rd[i]),
        .serial_in(CH_SERIAL_IN[i]),
        .clear_send_n(CH_CLEAR_SEND_N[i]),
        .set_ready_n(CH_SET_READY_N[i]),
        .carrier_detect_n(CH_CARRIER_DETECT_N[i]),
        .ring_indicator_n(CH_RING_INDICATOR_N[i]),
        .serial_out(CH_SERIAL_OUT[i]),
        .request_send_n(CH_REQUEST_SEND_N[i]),
        .terminal_ready_n(CH_TERMINAL_READY_N[i])
      );
    end
  endgenerate

  // timer clock pick; edge seen from the second and third sync stages only
  assign ext_edge = st.ext_s2 && !st.ext_s3;
  assign tmr_tick = st.tmr_ctl[TMR_EN] && (st.tmr_ctl[TMR_EXT] ? ext_edge : 1'b1);

  // shared registers, channel init pulses, timer and read data
  always_comb
  begin
    next_st = st;
    next_st.boot = 1'b0;
    // boot loads every channel, a soft reset only those named
    if (st.boot)
      next_st.chan_init = CH_ALL;
    else if (cfg_wr && reg_idx == CFG_RESET)
      next_st.chan_init = wdata[CH_NUM-1:0];
    else
      next_st.chan_init = CH_NONE;
    if (cfg_wr && reg_idx == CFG_BCAST)
      next_st.bcast = wdata;
    if (cfg_wr && reg_idx == CFG_TCTL)
      next_st.tmr_ctl = wdata;
    // external timer clock is slow and asynchronous, so it is synchronised
    next_st.ext_s1 = TIMER_EXT_CLOCK;
    next_st.ext_s2 = st.ext_s1;
    next_st.ext_s3 = st.ext_s2;
    // a clear request wins over a tick in the same cycle
    if (cfg_wr && reg_idx == CFG_TCTL && wdata[TMR_CLR])
      next_st.tmr_cnt = CNT_RST;
    else if (tmr_tick)
      next_st.tmr_cnt = st.tmr_cnt + 16'h0001;
    // read data; broadcast is not cleared for reads, software must clear it
    next_st.doe = rd_act;
    next_st.dout = REG_RST;
    if (rd_act && cfg_sel)
    begin
      case (reg_idx)
        CFG_TCTL: next_st.dout = st.tmr_ctl;
        CFG_TLSB: next_st.dout = st.tmr_cnt[7:0];
        CFG_TMSB: next_st.dout = st.tmr_cnt[15:8];
        CFG_BCAST: next_st.dout = st.bcast;
        default: next_st.dout = REG_RST;
      endcase
    end
    else if (rd_act && chan_ok)
      next_st.dout = chan_rd[chan];
  end

  // state register
  always_ff @(posedge CLK or negedge rst_sync)
  begin
    if (!rst_sync)
      st <= ST_RST;
    else
      st <= next_st;
  end

  assign DATA_OUT = st.dout;
  assign DATA_OE = st.doe;

  // checks on the decode, reset and timer paths
  chk_select_gate: assert property (@(posedge CLK) disable iff (!rst_sync)
    wr_pulse |-> !$past(CS_N))
    else $error("write taken without chip select");

  chk_read_gate: assert property (@(posedge CLK) disable iff (!rst_sync)
    (CS_N && $past(CS_N)) |=> !DATA_OE)
    else $error("data driven without chip select");

  chk_channel_pick: assert property (@(posedge CLK) disable iff (!rst_sync)
    (wr_pulse && chan_ok && !st.bcast[BCAST_EN]) |-> (chan_wr == (4'h1 << chan)))
    else $error("wrong channel written");

  chk_reserved_drop: assert property (@(posedge CLK) disable iff (!rst_sync)
    (wr_pulse && !chan_ok) |-> (chan_wr == CH_NONE))
    else $error("reserved or shared address wrote a channel");

  chk_boot_init: assert property (@(posedge CLK) disable iff (!ARST_N)
    $rose(rst_sync) |=> (st.chan_init == CH_ALL) ##1 (st.chan_init == CH_NONE))
    else $error("channels not initialised after reset release");

  chk_soft_reset: assert property (@(posedge CLK) disable iff (!rst_sync)
    (cfg_wr && reg_idx == CFG_RESET && !st.boot) |=>
      (st.chan_init == $past(wdata[CH_NUM-1:0])))
    else $error("soft reset did not reach the named channels");

  chk_timer_ext: assert property (@(posedge CLK) disable iff (!rst_sync)
    (st.tmr_ctl[TMR_EN] && st.tmr_ctl[TMR_EXT] && !ext_edge && !cfg_wr) |=>
      (st.tmr_cnt == $past(st.tmr_cnt)))
    else $error("timer moved without an external clock edge");

  chk_timer_step: assert property (@(posedge CLK) disable iff (!rst_sync)
    (tmr_tick && !cfg_wr) |=> (st.tmr_cnt == $past(st.tmr_cnt) + 16'h0001))
    else $error("timer did not advance by one");

  chk_bcast_write: assert property (@(posedge CLK) disable iff (!rst_sync)
    (wr_pulse && chan_ok && st.bcast[BCAST_EN]) |-> (chan_wr == CH_ALL))
    else $error("broadcast write missed a channel");

  chk_cfg_route: assert property (@(posedge CLK) disable iff (!rst_sync)
    (wr_pulse && cfg_sel) |-> (chan_wr == CH_NONE))
    else $error("shared register write leaked into a channel");

  // checks on read answers, init pulses and shared register stores
  chk_read_enable: assert property (@(posedge CLK) disable iff (!rst_sync)
    rd_act |=> DATA_OE)
    else $error("read not answered with data enable");

  chk_reserved_read: assert property (@(posedge CLK) disable iff (!rst_sync)
    (rd_act && !cfg_sel && !chan_ok) |=> (DATA_OUT == REG_RST))
    else $error("reserved address read returned data");

  chk_cfg_readback: assert property (@(posedge CLK) disable iff (!rst_sync)
    (rd_act && cfg_sel && reg_idx == CFG_BCAST) |=> (DATA_OUT == $past(st.bcast)))
    else $error("shared register read returned wrong value");

  // the sampled release level keeps the release edge itself out of the antecedent
  chk_boot_all: assert property (@(posedge CLK) disable iff (!rst_sync)
    (st.boot && rst_sync) |=> (st.chan_init == CH_ALL))
    else $error("boot did not initialise every channel");

  chk_init_pulse: assert property (@(posedge CLK) disable iff (!rst_sync)
    (!st.boot && !(cfg_wr && reg_idx == CFG_RESET)) |=> (st.chan_init == CH_NONE))
    else $error("channel init held longer than one cycle");

  chk_timer_clear: assert property (@(posedge CLK) disable iff (!rst_sync)
    (cfg_wr && reg_idx == CFG_TCTL && wdata[TMR_CLR]) |=> (st.tmr_cnt == CNT_RST))
    else $error("timer clear request ignored");

  chk_timer_hold: assert property (@(posedge CLK) disable iff (!rst_sync)
    (!st.tmr_ctl[TMR_EN] && !cfg_wr) |=> (st.tmr_cnt == $past(st.tmr_cnt)))
    else $error("timer moved while disabled");

  chk_bcast_store: assert property (@(posedge CLK) disable iff (!rst_sync)
    (cfg_wr && reg_idx == CFG_BCAST) |=> (st.bcast == $past(wdata)))
    else $error("broadcast control not stored");

  chk_idle_nowrite: assert property (@(posedge CLK) disable iff (!rst_sync)
    !wr_pulse |-> (chan_wr == CH_NONE))
    else $error("channel written without a write strobe");
endmodule
`default_nettype wire

/* qucsr_pkg.sv */
// shared constants for the quad serial host port, channel select and reset block
package qucsr_pkg;
  // channel count and bus widths
  localparam int CH_NUM = 4;
  localparam int ADR_W = 8;
  localparam int DAT_W = 8;
  localparam int IDX_W = 4;
  localparam int CNT_W = 16;
  // host address fields
  localparam int A_CFG = 7;
  localparam int A_RSV = 6;
  localparam int A_CH_HI = 5;
  localparam int A_CH_LO = 4;
  // channel register indices (address bits 3:0)
  localparam logic [3:0] CH_MCTL = 4'h4;
  localparam logic [3:0] CH_LST = 4'h5;
  localparam logic [3:0] CH_MSR = 4'h6;
  localparam logic [3:0] CH_SCR = 4'h7;
  localparam logic [3:0] CH_FEAT = 4'h8;
  // shared configuration register indices (address bit 7 set)
  localparam logic [3:0] CFG_TCTL = 4'h1;
  localparam logic [3:0] CFG_TLSB = 4'h2;
  localparam logic [3:0] CFG_TMSB = 4'h3;
  localparam logic [3:0] CFG_RESET = 4'h4;
  localparam logic [3:0] CFG_BCAST = 4'h5;
  // field positions
  localparam int MCTL_DTR = 0;
  localparam int MCTL_RTS = 1;
  localparam int MCTL_IR = 6;
  localparam int FEAT_RXPOL = 4;
  localparam int BCAST_EN = 0;
  localparam int TMR_EN = 0;
  localparam int TMR_EXT = 1;
  localparam int TMR_CLR = 2;
  localparam int MSR_CTS = 4;
  localparam int MSR_DSR = 5;
  localparam int MSR_RI = 6;
  localparam int MSR_CD = 7;
  localparam int LST_RX = 0;
  // reset values
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [3:0] CH_ALL = 4'hf;
  localparam logic [3:0] CH_NONE = 4'h0;
endpackage

/* qucsr_bus_decode.sv */
// host strobe qualification and address decode for both bus styles
`timescale 1ns/1ns
`default_nettype none
module qucsr_bus_decode
  import qucsr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // host pins
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [ADR_W-1:0] addr,
  input wire logic [DAT_W-1:0] wdata,
  input wire logic bus_style,
  // decoded access
  output logic wr_pulse,
  output logic rd_act,
  output logic cfg_sel,
  output logic chan_ok,
  output logic [1:0] chan,
  output logic [IDX_W-1:0] reg_idx,
  output logic [DAT_W-1:0] data
);
  typedef struct packed {
    logic wr_prev;
    logic wr_pulse;
    logic rd_act;
    logic [ADR_W-1:0] addr;
    logic [DAT_W-1:0] data;
  } qucsr_dec_t;

  qucsr_dec_t st;
  qucsr_dec_t next_st;
  logic wr_now;
  logic rd_now;

  // strobe style: separate strobes; other style: select is the strobe, write pin is r/w
  always_comb
  begin
    next_st = st;
    if (bus_style)
    begin
      rd_now = !cs_n && !rd_n;
      wr_now = !cs_n && !wr_n;
    end
    else
    begin
      rd_now = !cs_n && wr_n;
      wr_now = !cs_n && !wr_n;
    end
    next_st.wr_prev = wr_now;
    next_st.wr_pulse = wr_now && !st.wr_prev; // one write per strobe
    next_st.rd_act = rd_now;
    if ((wr_now && !st.wr_prev) || rd_now)
    begin
      next_st.addr = addr;
      next_st.data = wdata;
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st <= '0;
    else
      st <= next_st;
  end

  assign wr_pulse = st.wr_pulse;
  assign rd_act = st.rd_act;
  assign cfg_sel = st.addr[A_CFG];
  assign chan_ok = !st.addr[A_CFG] && !st.addr[A_RSV];
  assign chan = st.addr[A_CH_HI:A_CH_LO];
  assign reg_idx = st.addr[IDX_W-1:0];
  assign data = st.data;

  chk_style_read: assert property (@(posedge clk) disable iff (!rst_n)
    (!bus_style && !cs_n && wr_n) |=> rd_act)
    else $error("read not seen in select-strobe style");
endmodule
`default_nettype wire

/* qucsr_channel.sv */
// one serial channel: mode, modem control and line level registers
`timescale 1ns/1ns
`default_nettype none
module qucsr_channel
  import qucsr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register access
  input wire logic init,
  input wire logic strap,
  input wire logic wr_en,
  input wire logic [IDX_W-1:0] reg_idx,
  input wire logic [DAT_W-1:0] wdata,
  output logic [DAT_W-1:0] rdata,
  // serial and modem pins
  input wire logic serial_in,
  input wire logic clear_send_n,
  input wire logic set_ready_n,
  input wire logic carrier_detect_n,
  input wire logic ring_indicator_n,
  output logic serial_out,
  output logic request_send_n,
  output logic terminal_ready_n
);
  typedef struct packed {
    logic [7:0] mctl;
    logic [7:0] feat;
    logic [7:0] scr;
    logic tx;
    logic rts_n;
    logic dtr_n;
    logic rx_mark;
  } qucsr_ch_t;

  // outputs idle inactive and line high while reset is held
  localparam qucsr_ch_t ST_RST = '{REG_RST, REG_RST, REG_RST, 1'b1, 1'b1, 1'b1, 1'b1};

  qucsr_ch_t st;
  qucsr_ch_t next_st;

  // register writes, strap reload and pin levels
  always_comb
  begin
    next_st = st;
    if (init)
    begin
      next_st.mctl = REG_RST;
      next_st.mctl[MCTL_IR] = strap;
      next_st.feat = REG_RST;
      next_st.scr = REG_RST;
    end
    else if (wr_en)
    begin
      case (reg_idx)
        CH_MCTL: next_st.mctl = wdata;
        CH_SCR: next_st.scr = wdata;
        CH_FEAT: next_st.feat = wdata;
        default: next_st.scr = st.scr;
      endcase
    end
    next_st.tx = !st.mctl[MCTL_IR]; // idle high normal, low infrared
    next_st.rts_n = !st.mctl[MCTL_RTS];
    next_st.dtr_n = !st.mctl[MCTL_DTR];
    // infrared polarity: bit clear means low input is mark
    if (st.mctl[MCTL_IR])
      next_st.rx_mark = st.feat[FEAT_RXPOL] ? serial_in : !serial_in;
    else
      next_st.rx_mark = serial_in;
  end

  // state register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st <= ST_RST;
    else
      st <= next_st;
  end

  // read mux; modem inputs shown active high
  always_comb
  begin
    rdata = REG_RST;
    case (reg_idx)
      CH_MCTL: rdata = st.mctl;
      CH_SCR: rdata = st.scr;
      CH_FEAT: rdata = st.feat;
      CH_LST: rdata[LST_RX] = st.rx_mark;
      CH_MSR:
      begin
        rdata[MSR_CTS] = !clear_send_n;
        rdata[MSR_DSR] = !set_ready_n;
        rdata[MSR_RI] = !ring_indicator_n;
        rdata[MSR_CD] = !carrier_detect_n;
      end
      default: rdata = REG_RST;
    endcase
  end

  assign serial_out = st.tx;
  assign request_send_n = st.rts_n;
  assign terminal_ready_n = st.dtr_n;

  chk_strap_copy: assert property (@(posedge clk) disable iff (!rst_n)
    init |=> (st.mctl[MCTL_IR] == $past(strap)))
    else $error("strap level not copied into mode bit");
  chk_tx_idle: assert property (@(posedge clk) disable iff (!rst_n)
    (st.mctl[MCTL_IR] && !init && !wr_en) |=> ##1 !serial_out)
    else $error("transmit line not idle low in infrared mode");
  chk_rx_polarity: assert property (@(posedge clk) disable iff (!rst_n)
    (st.mctl[MCTL_IR] && !st.feat[FEAT_RXPOL]) |=> (st.rx_mark == !$past(serial_in)))
    else $error("infrared receive polarity wrong");
  chk_modem_out: assert property (@(posedge clk) disable iff (!rst_n)
    $changed(st.mctl[MCTL_RTS]) |=> (request_send_n == !$past(st.mctl[MCTL_RTS])))
    else $error("request-to-send does not follow control bit");
endmodule
`default_nettype wire

/* qucsr_host_model.sv */
// behavioural host processor driving the parallel port in either bus style
`timescale 1ns/1ns
`default_nettype none
module qucsr_host_model
  import qucsr_pkg::*;
(
  // clock and strap
  input wire logic clk,
  input wire logic style,
  // host pins
  output logic cs_n,
  output logic rd_n,
  output logic wr_n,
  output logic [ADR_W-1:0] addr,
  output logic [DAT_W-1:0] wdata,
  // answer from the port
  input wire logic [DAT_W-1:0] rdata,
  input wire logic oe
);
  // idle bus: select and strobes high before the first cycle
  initial
  begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    addr = 8'h00;
    wdata = 8'h00;
  end

  // one write; sel is the select level so a deselected cycle can be issued
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic sel);
    @(negedge clk);
    cs_n = sel;
    addr = a;
    wdata = d;
    wr_n = 1'b0;
    rd_n = style; // read strobe low too in r/w style, where it must be ignored
    @(negedge clk);
    cs_n = 1'b1;
    wr_n = 1'b1;
    rd_n = 1'b1;
    addr = ~a; // released lines do not keep their last value
    wdata = ~d;
    repeat (3) @(negedge clk);
  endtask

  // one read; r/w pin high selects read in select-strobe style
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic e);
    @(negedge clk);
    cs_n = 1'b0;
    addr = a;
    wr_n = 1'b1;
    rd_n = 1'b0;
    repeat (3) @(negedge clk);
    d = rdata;
    e = oe;
    cs_n = 1'b1;
    rd_n = 1'b1;
    addr = ~a;
    repeat (3) @(negedge clk);
  endtask
endmodule
`default_nettype wire

/* tb_top.sv */
// self-checking bench for the quad serial host port against a register model
`timescale 1ns/1ns
`default_nettype none
module tb_top import qucsr_pkg::*; ();
  logic clk, arst_n, cs_n, rd_n, wr_n, bus_style, ir_strap, tmr_clk, re, bcast;
  logic [7:0] addr, din, dout, rv;
  logic oe;
  logic [3:0] sin, sout, rts_n, dtr_n, cts_n, dsr_n, cd_n, ri_n;
  logic [7:0] mctl [4];
  logic [7:0] scr [4];
  logic [7:0] feat [4];
  logic [31:0] rnd;
  int num_errors, total_checks, cycles, seed;

  qucsr_top uut (.CLK(clk), .ARST_N(arst_n), .CS_N(cs_n), .READ_STROBE_N(rd_n),
    .WRITE_STROBE_N(wr_n), .ADDR(addr), .DATA_IN(din), .DATA_OUT(dout), .DATA_OE(oe),
    .BUS_STYLE(bus_style), .INFRARED_STRAP(ir_strap), .TIMER_EXT_CLOCK(tmr_clk),
    .CH_SERIAL_IN(sin), .CH_SERIAL_OUT(sout), .CH_REQUEST_SEND_N(rts_n),
    .CH_TERMINAL_READY_N(dtr_n), .CH_CLEAR_SEND_N(cts_n), .CH_SET_READY_N(dsr_n),
    .CH_CARRIER_DETECT_N(cd_n), .CH_RING_INDICATOR_N(ri_n));

  qucsr_host_model uhost (.clk(clk), .style(bus_style), .cs_n(cs_n), .rd_n(rd_n),
    .wr_n(wr_n), .addr(addr), .wdata(din), .rdata(dout), .oe(oe));

  // 25 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // hang guard: the whole run needs under a thousand cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // compare of a register byte
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t reg got=%h exp=%h", $time, got, exp);
    end
  endtask

  // compare of a pin vector
  task automatic chk_pin(input logic [3:0] got, input logic [3:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t pin got=%h exp=%h", $time, got, exp);
    end
  endtask

  // idle transmit levels and modem outputs follow the model's mode registers
  task automatic pins_now();
    logic [3:0] es, er, ed;
    for (int i = 0; i < CH_NUM; i++)
    begin
      es[i] = ~mctl[i][MCTL_IR];
      er[i] = ~mctl[i][MCTL_RTS];
      ed[i] = ~mctl[i][MCTL_DTR];
    end
    chk_pin(sout, es);
    chk_pin(rts_n, er);
    chk_pin(dtr_n, ed);
  endtask

  // channel write, mirrored into the model with broadcast taken into account
  task automatic put(input int ch, input logic [3:0] idx, input logic [7:0] d);
    uhost.wr({2'b00, ch[1:0], idx}, d, 1'b0);
    for (int i = 0; i < CH_NUM; i++)
      if (bcast || i == ch)
        case (idx)
          CH_MCTL: mctl[i] = d;
          CH_SCR: scr[i] = d;
          CH_FEAT: feat[i] = d;
          default: ;
        endcase
  endtask

  task automatic get(input int ch, input logic [3:0] idx, output logic [7:0] d);
    logic e;
    uhost.rd({2'b00, ch[1:0], idx}, d, e);
  endtask

  // read back every channel's scratch and mode register
  task automatic chk_all();
    for (int i = 0; i < CH_NUM; i++)
    begin
      get(i, CH_SCR, rv);
      chk_reg(rv, scr[i]);
      get(i, CH_MCTL, rv);
      chk_reg(rv, mctl[i]);
    end
  endtask

  // model reset of the named channels, mode bit taken from the strap
  task automatic mdl_reset(input logic [3:0] which);
    for (int i = 0; i < CH_NUM; i++)
      if (which[i])
      begin
        mctl[i] = {1'b0, ir_strap, 6'h00};
        scr[i] = 8'h00;
        feat[i] = 8'h00;
      end
  endtask

  initial
  begin
    arst_n = 1'b0;
    bus_style = 1'b1;
    ir_strap = 1'b0;
    tmr_clk = 1'b0;
    sin = 4'hf; // far end idles high in normal mode
    {cts_n, dsr_n, cd_n, ri_n} = 16'hffff;
    seed = 32'hfdde;
    bcast = 1'b0;
    mdl_reset(CH_ALL);
    repeat (10) @(negedge clk);
    arst_n = 1'b1;
    repeat (6) @(negedge clk);
    // reset defaults and strap copy
    pins_now();
    uhost.rd({4'h0, CH_SCR}, rv, re);
    chk_pin({3'b000, re}, 4'h1);
    chk_all();
    $display("test reset done");
    // channel select in both bus styles, random data and modem outputs
    for (int s = 1; s >= 0; s--)
    begin
      bus_style = s[0];
      for (int c = 0; c < CH_NUM; c++)
      begin
        rnd = $random(seed);
        put(c, CH_SCR, rnd[7:0]);
        put(c, CH_MCTL, {6'h00, rnd[9:8]});
      end
      pins_now();
      chk_all();
    end
    // deselected and reserved cycles leave the registers alone
    uhost.wr({4'h0, CH_SCR}, ~scr[0], 1'b1);
    uhost.wr({4'h4, CH_SCR}, ~scr[0], 1'b0);
    get(0, CH_SCR, rv);
    chk_reg(rv, scr[0]);
    uhost.rd({4'h4, CH_SCR}, rv, re);
    chk_reg(rv, 8'h00);
    $display("test select done");
    // broadcast write reaches all channels, then reads with it cleared
    uhost.wr({4'h8, CFG_BCAST}, 8'h01, 1'b0);
    bcast = 1'b1;
    rnd = $random(seed);
    put(2, CH_SCR, rnd[7:0]);
    put(1, CH_MCTL, 8'h03);
    uhost.wr({4'h8, CFG_BCAST}, 8'h00, 1'b0);
    bcast = 1'b0;
    pins_now();
    chk_all();
    uhost.rd({4'h8, CFG_BCAST}, rv, re);
    chk_reg(rv, 8'h00);
    $display("test broadcast done");
    // soft reset of channels 0 and 2 with the infrared strap high
    ir_strap = 1'b1;
    uhost.wr({4'h8, CFG_RESET}, 8'h05, 1'b0);
    mdl_reset(4'h5);
    repeat (2) @(negedge clk);
    pins_now();
    chk_all();
    $display("test soft reset done");
    // receive decode: channel 0 infrared, channel 1 normal
    for (int k = 0; k < 4; k++)
    begin
      sin[0] = k[0];
      sin[1] = k[0];
      put(0, CH_FEAT, {3'b000, k[1], 4'h0});
      get(0, CH_LST, rv);
      chk_reg({7'h00, rv[LST_RX]}, {7'h00, k[1] ? k[0] : ~k[0]});
      get(1, CH_LST, rv);
      chk_reg({7'h00, rv[LST_RX]}, {7'h00, k[0]});
    end
    sin = 4'ha; // infrared channels 0 and 2 idle low, the rest high
    $display("test receive polarity done");
    // modem inputs seen in the status register
    repeat (4)
    begin
      rnd = $random(seed);
      {cts_n, dsr_n, cd_n, ri_n} = rnd[15:0];
      repeat (3) @(negedge clk);
      for (int c = 0; c < CH_NUM; c++)
      begin
        get(c, CH_MSR, rv);
        chk_reg(rv & 8'hf0, {~cd_n[c], ~ri_n[c], ~dsr_n[c], ~cts_n[c], 4'h0});
      end
    end
    $display("test modem inputs done");
    // timer counts external clock edges only
    uhost.wr({4'h8, CFG_TCTL}, 8'h04, 1'b0);
    uhost.wr({4'h8, CFG_TCTL}, 8'h03, 1'b0);
    repeat (7)
    begin
      tmr_clk = 1'b1;
      repeat (4) @(negedge clk);
      tmr_clk = 1'b0;
      repeat (4) @(negedge clk);
    end
    uhost.wr({4'h8, CFG_TCTL}, 8'h00, 1'b0);
    uhost.rd({4'h8, CFG_TLSB}, rv, re);
    chk_reg(rv, 8'h07);
    uhost.rd({4'h8, CFG_TMSB}, rv, re);
    chk_reg(rv, 8'h00);
    // internal tick: each write call spans 5 cycles, so 20 idle cycles give 25 counts
    uhost.wr({4'h8, CFG_TCTL}, 8'h04, 1'b0);
    uhost.wr({4'h8, CFG_TCTL}, 8'h01, 1'b0);
    repeat (20) @(negedge clk);
    uhost.wr({4'h8, CFG_TCTL}, 8'h00, 1'b0);
    uhost.rd({4'h8, CFG_TLSB}, rv, re);
    chk_reg(rv, 8'h19);
    $display("test timer done");
    // hardware reset in mid-run returns every channel to defaults
    ir_strap = 1'b0;
    sin = 4'hf; // every channel leaves reset in normal mode
    arst_n = 1'b0;
    mdl_reset(CH_ALL);
    repeat (2) @(negedge clk);
    pins_now();
    chk_pin({3'b000, oe}, 4'h0);
    arst_n = 1'b1;
    repeat (6) @(negedge clk);
    pins_now();
    chk_all();
    uhost.rd({4'h8, CFG_TLSB}, rv, re);
    chk_reg(rv, 8'h00);
    $display("test hardware reset done");
    close_out();
  end
endmodule
`default_nettype wire
